// ===== rtl/mbm_exec.sv
`default_nettype none
module mbm_exec
    import mbm_pkg::*;
#(
    parameter int NREGS = 16
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // instruction from the core
    input  wire mbm_instr_t   instr,
    output logic              busy,
    output logic              done,
    // condition flags passed through
    input  wire logic [7:0]   flags_in,
    output logic      [7:0]   flags_out,
    // memory port
    output var mbm_mem_req_t  mem,
    input  wire logic [7:0]   mem_rdata,
    input  wire logic         mem_ack,
    // register file observation
    input  wire logic [3:0]   dbg_idx,
    output logic      [7:0]   dbg_data
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_PRE   = 5'b00010,
        ST_MEM   = 5'b00100,
        ST_POST  = 5'b01000,
        ST_WAIT  = 5'b10000
    } mbm_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // register file and latched instruction
    logic [7:0]       regs_r [NREGS];
    mbm_state_t       st_r, st_nxt;
    mbm_instr_t       ins_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0]       flags_r;
    logic [7:0]       rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire is_ld_dec = ins_r.opcode == OPC_LOAD_POST_DEC;
    wire is_ld_inc = ins_r.opcode == OPC_LOAD_POST_INC;
    wire is_st_dec = ins_r.opcode == OPC_STORE_PRE_DEC;
    wire is_st_inc = ins_r.opcode == OPC_STORE_PRE_INC;
    wire is_load   = is_ld_dec | is_ld_inc;
    wire is_store  = is_st_dec | is_st_inc;
    wire is_w_pair = ins_r.opcode == OPC_WORD_PAIR;
    wire is_w_ind  = ins_r.opcode == OPC_WORD_IND;
    wire is_w_imm  = ins_r.opcode == OPC_WORD_IMM;
    wire is_word   = is_w_pair | is_w_ind | is_w_imm;

    wire new_known = instr.opcode inside {OPC_LOAD_POST_DEC, OPC_LOAD_POST_INC, OPC_STORE_PRE_DEC,
                                          OPC_STORE_PRE_INC, OPC_WORD_PAIR, OPC_WORD_IND, OPC_WORD_IMM};
    wire start     = (st_r == ST_IDLE) && instr.valid && new_known;

    // loads: op1 = {dst, ptr}; stores: op1 = {src, ptr}
    wire [3:0] reg_sel  = ins_r.op1[7:NIB_HI];
    wire [3:0] ptr_fld  = ins_r.op1[NIB_HI-1:0];
    wire [3:0] ptr_hi_i = {ptr_fld[3:1], 1'b0};
    wire [3:0] ptr_lo_i = {ptr_fld[3:1], 1'b1};
    wire       ext_sp   = ptr_fld[SPACE_BIT];
    wire       step_dec = is_ld_dec | is_st_dec;

    logic [15:0] ptr_cur, ptr_nxt;
    mbm_ptr_step u_step (
        .hi  (regs_r[ptr_hi_i]),
        .lo  (regs_r[ptr_lo_i]),
        .dec (step_dec),
        .cur (ptr_cur),
        .nxt (ptr_nxt)
    );

    // word sources: C4 op1=src op2=dst; C5 op1=indirect reg op2=dst; C6 op1=dst op2=hi op3=lo
    wire [3:0] w_src_r  = is_w_ind ? regs_r[ins_r.op1[3:0]][3:0] : ins_r.op1[3:0];
    wire [3:0] w_src_lo = {w_src_r[3:1], 1'b0};
    wire [3:0] w_dst    = is_w_imm ? {ins_r.op1[3:1], 1'b0} : {ins_r.op2[3:1], 1'b0};
    wire [7:0] w_hi     = is_w_imm ? ins_r.op2 : regs_r[w_src_lo];
    wire [7:0] w_lo     = is_w_imm ? ins_r.op3 : regs_r[w_src_lo | 4'h1];

    ////////////////////////////////////////////////////////////////////////////
    // timing: total cycles from start to done
    wire [CNT_W-1:0] cyc_total = is_word  ? CNT_W'(CYC_WORD)
                               : is_store ? CNT_W'(CYC_STORE)
                               :            CNT_W'(CYC_LOAD);
    wire             cnt_end   = cnt_r == cyc_total - CNT_W'(2);
    // only memory wait cycles stretch the instruction
    wire             cnt_hold  = (st_r == ST_MEM) && !mem_ack;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: if (start) st_nxt = ST_PRE;
            ST_PRE:  st_nxt = is_word ? ST_WAIT : ST_MEM;
            ST_MEM:  if (mem_ack) st_nxt = ST_POST;
            ST_POST: st_nxt = ST_WAIT;
            ST_WAIT: if (cnt_end) st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    wire pre_step  = (st_r == ST_PRE) && is_store;
    wire post_step = (st_r == ST_POST) && is_load;
    wire load_wr   = (st_r == ST_POST) && is_load;
    wire word_wr   = (st_r == ST_PRE) && is_word;
    // stores present the already stepped pointer
    wire [15:0] req_addr = pre_step ? ptr_nxt : ptr_cur;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= ST_IDLE;
            ins_r   <= '0;
            cnt_r   <= '0;
            rdata_r <= REG_RESET;
            flags_r <= FLAG_RESET;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= start ? '0 : (cnt_hold ? cnt_r : cnt_r + CNT_W'(1));
            flags_r <= flags_in;
            if (start) begin
                ins_r <= instr;
            end
            if (st_r == ST_MEM && mem_ack) begin
                rdata_r <= mem_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NREGS; i++) regs_r[i] <= REG_RESET;
        end else begin
            if (pre_step || post_step) begin
                regs_r[ptr_hi_i] <= ptr_nxt[15:8];
                regs_r[ptr_lo_i] <= ptr_nxt[7:0];
            end
            if (load_wr) begin
                regs_r[reg_sel] <= rdata_r;
            end
            if (word_wr) begin
                regs_r[w_dst]        <= w_hi;
                regs_r[w_dst | 4'h1] <= w_lo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory request and outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem      <= '0;
            dbg_data <= REG_RESET;
        end else begin
            dbg_data  <= regs_r[dbg_idx];
            mem.req   <= (st_nxt == ST_MEM);
            mem.we    <= is_store;
            mem.ext   <= ext_sp;
            mem.addr  <= req_addr;
            mem.wdata <= regs_r[reg_sel];
        end
    end

    assign busy      = st_r != ST_IDLE;
    assign done      = (st_r == ST_WAIT) && cnt_end;
    assign flags_out = flags_r;
endmodule : mbm_exec
`default_nettype wire

// ===== rtl/mbm_pkg.sv
`default_nettype none
package mbm_pkg;
    // opcodes
    localparam logic [7:0] OPC_LOAD_POST_DEC = 8'he2;
    localparam logic [7:0] OPC_LOAD_POST_INC = 8'he3;
    localparam logic [7:0] OPC_STORE_PRE_DEC = 8'hf2;
    localparam logic [7:0] OPC_STORE_PRE_INC = 8'hf3;
    localparam logic [7:0] OPC_WORD_PAIR     = 8'hc4;
    localparam logic [7:0] OPC_WORD_IND      = 8'hc5;
    localparam logic [7:0] OPC_WORD_IMM      = 8'hc6;
    // cycle counts per instruction
    localparam int         CYC_LOAD          = 10;
    localparam int         CYC_STORE         = 14;
    localparam int         CYC_WORD          = 8;
    localparam int         CNT_W             = 4;
    // operand byte field positions and reset values
    localparam int         NIB_HI            = 4;
    localparam int         SPACE_BIT         = 0;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam logic [7:0] FLAG_RESET        = 8'h00;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
        logic [7:0] op3;
    } mbm_instr_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        ext;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mbm_mem_req_t;
endpackage : mbm_pkg
`default_nettype wire

// ===== rtl/mbm_ptr_step.sv
`default_nettype none
// 16-bit pointer step, even register is the high byte
module mbm_ptr_step
    import mbm_pkg::*;
(
    // pointer in
    input  wire logic [7:0]  hi,
    input  wire logic [7:0]  lo,
    input  wire logic        dec,
    // pointer out
    output logic      [15:0] cur,
    output logic      [15:0] nxt
);
    assign cur = {hi, lo};
    assign nxt = dec ? cur - 16'h0001 : cur + 16'h0001;
endmodule : mbm_ptr_step
`default_nettype wire

// ===== test/mbm_asserts.sv
`default_nettype none
module mbm_asserts
    import mbm_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire mbm_instr_t   instr,
    input wire logic         busy,
    input wire logic         done,
    input wire logic [7:0]   flags_in,
    input wire logic [7:0]   flags_out,
    input wire mbm_mem_req_t mem,
    input wire logic         mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic sp_r;
    logic st_r;
    wire logic opk_mem = instr.opcode inside {OPC_LOAD_POST_DEC, OPC_LOAD_POST_INC,
                                              OPC_STORE_PRE_DEC, OPC_STORE_PRE_INC};
    wire logic opk_word = instr.opcode inside {OPC_WORD_PAIR, OPC_WORD_IND, OPC_WORD_IMM};
    wire logic take = instr.valid && !busy && (opk_mem || opk_word);
    // space and direction of the running transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_r <= 1'b0;
            st_r <= 1'b0;
        end else if (take) begin
            sp_r <= instr.op1[SPACE_BIT];
            st_r <= instr.opcode[4];
        end
    end
    AST_FLAGS: assert property ($past(rst_n) |-> flags_out == $past(flags_in))
        else $error("flags altered");
    AST_TAKE: assert property (take |=> busy)
        else $error("no busy after take");
    AST_WORD: assert property (take && opk_word |-> ##1 (!done)[*6] ##1 done)
        else $error("word load not 8 cycles");
    AST_START: assert property (take && opk_mem |-> ##[1:2] mem.req)
        else $error("no memory request");
    AST_HOLD: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.wdata))
        else $error("request dropped early");
    AST_SPACE: assert property (mem.req |-> mem.ext == sp_r)
        else $error("wrong memory space");
    AST_DIR: assert property (mem.req |-> mem.we == st_r)
        else $error("wrong direction");
    AST_PULSE: assert property (done |=> !done)
        else $error("done too long");
    AST_IDLE: assert property (done |=> !busy && !mem.req)
        else $error("busy after done");
    cover property (take && opk_word);
    cover property (mem.req && mem.we && mem.ext);
    cover property (mem.req && !mem_ack);
endmodule : mbm_asserts
bind mbm_exec mbm_asserts i_chk (.clk(clk), .rst_n(rst_n), .instr(instr), .busy(busy), .done(done),
    .flags_in(flags_in), .flags_out(flags_out), .mem(mem), .mem_ack(mem_ack));
`default_nettype wire

// ===== test/mbm_mem_model.sv
`default_nettype none
module mbm_mem_model
    import mbm_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire mbm_mem_req_t mem,
    input  wire logic [1:0]   wait_cyc,
    output logic      [7:0]   mem_rdata,
    output logic              mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] code_m [256];
    logic [7:0] ext_m [256];
    logic [1:0] cnt_r;
    wire logic [7:0] rd_sel = mem.ext ? ext_m[mem.addr[7:0]] : code_m[mem.addr[7:0]];
    assign mem_ack = mem.req && (cnt_r == wait_cyc);
    // bus shows garbage outside the answer
    assign mem_rdata = mem_ack ? rd_sel : ~rd_sel;
    initial begin
        for (int i = 0; i < 256; i++) begin
            code_m[i] = 8'(i) ^ 8'h5a;
            ext_m[i] = 8'(i) ^ 8'ha5;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || mem_ack || !mem.req) cnt_r <= 2'h0;
        else cnt_r <= cnt_r + 2'h1;
        if (mem_ack && mem.we && mem.ext) ext_m[mem.addr[7:0]] <= mem.wdata;
        if (mem_ack && mem.we && !mem.ext) code_m[mem.addr[7:0]] <= mem.wdata;
    end
endmodule : mbm_mem_model
`default_nettype wire

// ===== test/memory_block_move_and_word_load_tb.sv
`default_nettype none
module memory_block_move_and_word_load_tb
    import mbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    mbm_instr_t instr = '0;
    logic [7:0] flags_in = 8'h00;
    logic [3:0] dbg_idx = 4'h0;
    logic [1:0] wait_cyc = 2'h0;
    logic busy, done, mem_ack;
    logic [7:0] flags_out, mem_rdata, dbg_data;
    mbm_mem_req_t mem;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    always @(posedge clk) flags_in <= flags_in + 8'h13;
    mbm_exec i_dut (.clk(clk), .rst_n(rst_n), .instr(instr), .busy(busy), .done(done), .flags_in(flags_in),
        .flags_out(flags_out), .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dbg_idx(dbg_idx),
        .dbg_data(dbg_data));
    mbm_mem_model i_mem (.clk(clk), .rst_n(rst_n), .mem(mem), .wait_cyc(wait_cyc), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic exec(input logic [7:0] opc, a, b, c, input int ncyc);
        int n;
        logic [7:0] fl_exp;
        n = 0;
        @(posedge clk);
        instr <= '{1'b1, opc, a, b, c};
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
        chk("busy", 16'h0001, 16'(busy));
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        // done is sampled at edge ncyc-1 after the take, seen just after edge ncyc-2
        fl_exp = flags_in - 8'h13;
        chk("cycles", 16'(ncyc - 2), 16'(n));
        chk("flags", 16'(fl_exp), 16'(flags_out));
    endtask : exec
    task automatic rd_reg(input logic [3:0] idx, input logic [7:0] exp);
        @(posedge clk);
        dbg_idx <= idx;
        @(posedge clk);
        #1;
        chk("reg", 16'(exp), 16'(dbg_data));
    endtask : rd_reg
    task automatic pair(input logic [3:0] idx, input logic [15:0] exp);
        rd_reg(idx, exp[15:8]);
        rd_reg(idx + 4'h1, exp[7:0]);
    endtask : pair
    ////////////////////////////////////////////////////////////////
    task automatic t_word();
        exec(OPC_WORD_IMM, 8'h06, 8'h21, 8'hff, CYC_WORD);
        pair(4'h6, 16'h21ff);
        exec(OPC_WORD_IMM, 8'h00, 8'h7f, 8'h00, CYC_WORD);
        exec(OPC_WORD_IMM, 8'h0a, 8'h06, 8'h00, CYC_WORD);
        exec(OPC_WORD_PAIR, 8'h06, 8'h04, 8'h00, CYC_WORD);
        pair(4'h4, 16'h21ff);
        pair(4'h6, 16'h21ff);
        exec(OPC_WORD_IND, 8'h0a, 8'h02, 8'h00, CYC_WORD);
        pair(4'h2, 16'h21ff);
    endtask : t_word
    task automatic t_store_inc();
        wait_cyc <= 2'h1;
        exec(OPC_STORE_PRE_INC, 8'h07, 8'h00, 8'h00, CYC_STORE + 1);
        pair(4'h6, 16'h2200);
        rd_reg(4'h0, 8'h7f);
        chk("ext_mem", 16'h007f, 16'(i_mem.ext_m[8'h00]));
        chk("code_mem", 16'h005a, 16'(i_mem.code_m[8'h00]));
    endtask : t_store_inc
    task automatic t_store_dec();
        wait_cyc <= 2'h0;
        exec(OPC_WORD_IMM, 8'h06, 8'h30, 8'h00, CYC_WORD);
        exec(OPC_STORE_PRE_DEC, 8'h06, 8'h00, 8'h00, CYC_STORE);
        pair(4'h6, 16'h2fff);
        chk("code_mem", 16'h007f, 16'(i_mem.code_m[8'hff]));
        chk("ext_mem", 16'h005a, 16'(i_mem.ext_m[8'hff]));
    endtask : t_store_dec
    task automatic t_load();
        exec(OPC_LOAD_POST_INC, 8'h86, 8'h00, 8'h00, CYC_LOAD);
        rd_reg(4'h8, 8'h7f);
        pair(4'h6, 16'h3000);
        wait_cyc <= 2'h2;
        exec(OPC_LOAD_POST_DEC, 8'h97, 8'h00, 8'h00, CYC_LOAD + 2);
        rd_reg(4'h9, 8'h7f);
        pair(4'h6, 16'h2fff);
    endtask : t_load
    task print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_word();
        t_store_inc();
        t_store_dec();
        t_load();
        print_verdict();
    end
endmodule : memory_block_move_and_word_load_tb
`default_nettype wire
